// File: rtl/irq_enable_priority_regs.sv
// interrupt enable and priority registers with merged cpu request
// assumes synchronous request inputs, single-word AHB-Lite accesses, one clock
`timescale 1ns/1ps
module irq_enable_priority_regs (
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic [7:0] prio_src_req, // timer1,oc1,ic1,ext0,timer2,oc2,ic2,dma0 flags
  input wire logic [15:0] en3_src_req, // request flags at en3 bit positions
  input wire logic [15:0] en4_src_req, // request flags at en4 bit positions
  output logic cpu_irq_req, // merged request to the cpu
  output logic [2:0] cpu_irq_level, // highest pending priority level
  output logic irq // block interrupt, level
);

  // control registers and their next values
  irq_regs_pkg::ctrl_regs_s regs;
  irq_regs_pkg::ctrl_regs_s next_regs;
  // address phase held over into its data phase
  irq_regs_pkg::bus_req_s req;
  irq_regs_pkg::bus_req_s next_req;
  // sticky events, their mask and this cycle's sets and clears
  logic [irq_regs_pkg::EVT_W-1:0] status;
  logic [irq_regs_pkg::EVT_W-1:0] next_status;
  logic [irq_regs_pkg::EVT_W-1:0] mask;
  logic [irq_regs_pkg::EVT_W-1:0] next_mask;
  logic [irq_regs_pkg::EVT_W-1:0] evt_set;
  logic [irq_regs_pkg::EVT_W-1:0] evt_clr;
  // registered bus outputs
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  logic next_hresp;
  // request path
  logic next_cpu_irq_req;
  logic [2:0] next_cpu_irq_level;
  logic next_irq;
  logic pending;
  logic next_pending;
  logic [2:0] prio_vec [irq_regs_pkg::NUM_PRIO_SRC];
  logic [irq_regs_pkg::NUM_PRIO_SRC-1:0] prio_live;
  logic [2:0] best;
  logic any_en;
  logic [15:0] en3_live;
  logic [15:0] en4_live;
  // write strobes from the held address phase
  logic wr_en3;
  logic wr_en4;
  logic wr_prio0;
  logic wr_prio1;
  logic wr_status;
  logic wr_mask;
  logic bad_access;
  // enable bits by source
  logic pwm1_fault_a_irq_enable;
  logic realtime_clock_irq_enable;
  logic dma_ch5_done_irq_enable;
  logic codec_if_event_irq_enable;
  logic codec_if_error_irq_enable;
  logic quad_encoder1_irq_enable;
  logic pwm_unit1_irq_enable;
  logic dac_left_irq_enable;
  logic dac_right_irq_enable;
  logic quad_encoder2_irq_enable;
  logic pwm2_fault_a_irq_enable;
  logic pwm_unit2_irq_enable;
  logic can1_tx_ready_irq_enable;
  logic dma_ch7_done_irq_enable;
  logic dma_ch6_done_irq_enable;
  logic checksum_gen_irq_enable;
  logic uart2_error_irq_enable;
  logic uart1_error_irq_enable;
  // priority fields by source
  logic [2:0] timer1_irq_priority;
  logic [2:0] outcmp1_irq_priority;
  logic [2:0] incap1_irq_priority;
  logic [2:0] ext_irq0_priority;
  logic [2:0] timer2_irq_priority;
  logic [2:0] outcmp2_irq_priority;
  logic [2:0] incap2_irq_priority;
  logic [2:0] dma_ch0_done_priority;

  function automatic logic [2:0] field(input logic [15:0] r, input int lsb);
    field = r[lsb +: irq_regs_pkg::PRIO_W];
  endfunction : field

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == irq_regs_pkg::ADDR_EN3) || (a == irq_regs_pkg::ADDR_EN4) ||
                 (a == irq_regs_pkg::ADDR_PRIO0) || (a == irq_regs_pkg::ADDR_PRIO1) ||
                 (a == irq_regs_pkg::ADDR_STATUS) || (a == irq_regs_pkg::ADDR_MASK) ||
                 (a == irq_regs_pkg::ADDR_LEVEL);
  endfunction : known_addr

  // unimplemented bits never take a write, so they always read back zero
  function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] impl);
    masked = d & impl;
  endfunction : masked

  // enable bits taken out of the two enable registers
  assign pwm1_fault_a_irq_enable = regs.en3[irq_regs_pkg::EN3_PWM1_FLT]; // R12
  assign realtime_clock_irq_enable = regs.en3[irq_regs_pkg::EN3_RTC]; // R12
  assign dma_ch5_done_irq_enable = regs.en3[irq_regs_pkg::EN3_DMA5]; // R12
  assign codec_if_event_irq_enable = regs.en3[irq_regs_pkg::EN3_CODEC_EVT]; // R13
  assign codec_if_error_irq_enable = regs.en3[irq_regs_pkg::EN3_CODEC_ERR]; // R13
  assign quad_encoder1_irq_enable = regs.en3[irq_regs_pkg::EN3_QE1]; // R14
  assign pwm_unit1_irq_enable = regs.en3[irq_regs_pkg::EN3_PWM1]; // R14
  assign dac_left_irq_enable = regs.en4[irq_regs_pkg::EN4_DAC_L]; // R15
  assign dac_right_irq_enable = regs.en4[irq_regs_pkg::EN4_DAC_R]; // R15
  assign quad_encoder2_irq_enable = regs.en4[irq_regs_pkg::EN4_QE2]; // R16
  assign pwm2_fault_a_irq_enable = regs.en4[irq_regs_pkg::EN4_PWM2_FLT]; // R16
  assign pwm_unit2_irq_enable = regs.en4[irq_regs_pkg::EN4_PWM2]; // R16
  assign can1_tx_ready_irq_enable = regs.en4[irq_regs_pkg::EN4_CAN1_TX]; // R17
  assign dma_ch7_done_irq_enable = regs.en4[irq_regs_pkg::EN4_DMA7]; // R17
  assign dma_ch6_done_irq_enable = regs.en4[irq_regs_pkg::EN4_DMA6]; // R17
  assign checksum_gen_irq_enable = regs.en4[irq_regs_pkg::EN4_CRC]; // R18
  assign uart2_error_irq_enable = regs.en4[irq_regs_pkg::EN4_UART2_ERR]; // R18
  assign uart1_error_irq_enable = regs.en4[irq_regs_pkg::EN4_UART1_ERR]; // R18

  // priority codes map straight to levels 1..7, 000 means off
  assign timer1_irq_priority = field(regs.prio0, irq_regs_pkg::PF3_LSB); // R6 R3 R4
  assign outcmp1_irq_priority = field(regs.prio0, irq_regs_pkg::PF2_LSB); // R7
  assign incap1_irq_priority = field(regs.prio0, irq_regs_pkg::PF1_LSB); // R8
  assign ext_irq0_priority = field(regs.prio0, irq_regs_pkg::PF0_LSB); // R9
  assign timer2_irq_priority = field(regs.prio1, irq_regs_pkg::PF3_LSB); // R10
  assign outcmp2_irq_priority = field(regs.prio1, irq_regs_pkg::PF2_LSB); // R10
  assign incap2_irq_priority = field(regs.prio1, irq_regs_pkg::PF1_LSB); // R10
  assign dma_ch0_done_priority = field(regs.prio1, irq_regs_pkg::PF0_LSB); // R11

  always_comb begin
    prio_vec[0] = timer1_irq_priority;
    prio_vec[1] = outcmp1_irq_priority;
    prio_vec[2] = incap1_irq_priority;
    prio_vec[3] = ext_irq0_priority;
    prio_vec[4] = timer2_irq_priority;
    prio_vec[5] = outcmp2_irq_priority;
    prio_vec[6] = incap2_irq_priority;
    prio_vec[7] = dma_ch0_done_priority;
  end

  // enable-only sources: a flag passes only through its own enable bit
  always_comb begin
    en3_live = 16'h0000;
    en3_live[irq_regs_pkg::EN3_PWM1_FLT] = en3_src_req[irq_regs_pkg::EN3_PWM1_FLT] &&
      pwm1_fault_a_irq_enable; // R1
    en3_live[irq_regs_pkg::EN3_RTC] = en3_src_req[irq_regs_pkg::EN3_RTC] &&
      realtime_clock_irq_enable; // R1
    en3_live[irq_regs_pkg::EN3_DMA5] = en3_src_req[irq_regs_pkg::EN3_DMA5] &&
      dma_ch5_done_irq_enable; // R1
    en3_live[irq_regs_pkg::EN3_CODEC_EVT] = en3_src_req[irq_regs_pkg::EN3_CODEC_EVT] &&
      codec_if_event_irq_enable; // R1
    en3_live[irq_regs_pkg::EN3_CODEC_ERR] = en3_src_req[irq_regs_pkg::EN3_CODEC_ERR] &&
      codec_if_error_irq_enable; // R1
    en3_live[irq_regs_pkg::EN3_QE1] = en3_src_req[irq_regs_pkg::EN3_QE1] &&
      quad_encoder1_irq_enable; // R1
    en3_live[irq_regs_pkg::EN3_PWM1] = en3_src_req[irq_regs_pkg::EN3_PWM1] &&
      pwm_unit1_irq_enable; // R1
  end

  always_comb begin
    en4_live = 16'h0000;
    en4_live[irq_regs_pkg::EN4_DAC_L] = en4_src_req[irq_regs_pkg::EN4_DAC_L] &&
      dac_left_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_DAC_R] = en4_src_req[irq_regs_pkg::EN4_DAC_R] &&
      dac_right_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_QE2] = en4_src_req[irq_regs_pkg::EN4_QE2] &&
      quad_encoder2_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_PWM2_FLT] = en4_src_req[irq_regs_pkg::EN4_PWM2_FLT] &&
      pwm2_fault_a_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_PWM2] = en4_src_req[irq_regs_pkg::EN4_PWM2] &&
      pwm_unit2_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_CAN1_TX] = en4_src_req[irq_regs_pkg::EN4_CAN1_TX] &&
      can1_tx_ready_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_DMA7] = en4_src_req[irq_regs_pkg::EN4_DMA7] &&
      dma_ch7_done_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_DMA6] = en4_src_req[irq_regs_pkg::EN4_DMA6] &&
      dma_ch6_done_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_CRC] = en4_src_req[irq_regs_pkg::EN4_CRC] &&
      checksum_gen_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_UART2_ERR] = en4_src_req[irq_regs_pkg::EN4_UART2_ERR] &&
      uart2_error_irq_enable; // R1
    en4_live[irq_regs_pkg::EN4_UART1_ERR] = en4_src_req[irq_regs_pkg::EN4_UART1_ERR] &&
      uart1_error_irq_enable; // R1
  end

  // a prioritised source is live only while flagged with a nonzero field
  always_comb begin
    for (int i = 0; i < irq_regs_pkg::NUM_PRIO_SRC; i++) begin
      prio_live[i] = prio_src_req[i] && (prio_vec[i] != irq_regs_pkg::PRIO_OFF); // R19 R5
    end
  end

  // ranking: pick the highest level among live prioritised sources
  always_comb begin
    best = irq_regs_pkg::PRIO_OFF;
    for (int i = 0; i < irq_regs_pkg::NUM_PRIO_SRC; i++) begin
      if (prio_live[i] && prio_vec[i] > best) begin
        best = prio_vec[i]; // R3 R4
      end
    end
    // enable-only sources never outrank a prioritised one
    any_en = (|en3_live) || (|en4_live); // R1 R12 R13 R14 R15 R16 R17 R18
    if (any_en && best == irq_regs_pkg::PRIO_OFF) begin
      best = irq_regs_pkg::PRIO_MIN; // R4
    end
    next_cpu_irq_level = best;
    next_cpu_irq_req = (best != irq_regs_pkg::PRIO_OFF); // R19
    next_pending = next_cpu_irq_req;
  end

  // bus: capture address phase, act in data phase, zero wait
  always_comb begin
    next_req.valid = hsel && hready &&
                     (htrans == irq_regs_pkg::HTRANS_NONSEQ || htrans == irq_regs_pkg::HTRANS_SEQ);
    next_req.write = hwrite;
    next_req.addr = haddr[7:0];
  end

  // write strobes; an unmapped access is answered okay but flagged
  always_comb begin
    wr_en3 = 1'b0;
    wr_en4 = 1'b0;
    wr_prio0 = 1'b0;
    wr_prio1 = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    bad_access = req.valid && !known_addr(req.addr);
    if (req.valid && req.write) begin
      case (req.addr)
        irq_regs_pkg::ADDR_EN3: wr_en3 = 1'b1;
        irq_regs_pkg::ADDR_EN4: wr_en4 = 1'b1;
        irq_regs_pkg::ADDR_PRIO0: wr_prio0 = 1'b1;
        irq_regs_pkg::ADDR_PRIO1: wr_prio1 = 1'b1;
        irq_regs_pkg::ADDR_STATUS: wr_status = 1'b1;
        irq_regs_pkg::ADDR_MASK: wr_mask = 1'b1;
        default: wr_en3 = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_regs = regs;
    if (wr_en3) begin
      next_regs.en3 = masked(hwdata[15:0], irq_regs_pkg::EN3_IMPL); // R2
    end
    if (wr_en4) begin
      next_regs.en4 = masked(hwdata[15:0], irq_regs_pkg::EN4_IMPL); // R2
    end
    if (wr_prio0) begin
      next_regs.prio0 = masked(hwdata[15:0], irq_regs_pkg::PRIO_IMPL); // R2
    end
    if (wr_prio1) begin
      next_regs.prio1 = masked(hwdata[15:0], irq_regs_pkg::PRIO_IMPL); // R2
    end
  end

  // hardware sets win over software clears, so no event is lost
  always_comb begin
    evt_set = '0;
    evt_set[irq_regs_pkg::EVT_RISE] = next_pending && !pending;
    evt_set[irq_regs_pkg::EVT_BAD_ADDR] = bad_access;
    evt_clr = wr_status ? hwdata[irq_regs_pkg::EVT_W-1:0] : '0;
    next_status = (status & ~evt_clr) | evt_set;
    next_mask = wr_mask ? hwdata[irq_regs_pkg::EVT_W-1:0] : mask;
    next_irq = |(next_status & next_mask);
  end

  // read data sees a write finishing in the same cycle
  always_comb begin
    next_hreadyout = 1'b1;
    next_hresp = 1'b0;
    next_hrdata = 32'h0000_0000;
    if (next_req.valid && !hwrite) begin
      case (haddr[7:0])
        irq_regs_pkg::ADDR_EN3: next_hrdata[15:0] = next_regs.en3;
        irq_regs_pkg::ADDR_EN4: next_hrdata[15:0] = next_regs.en4;
        irq_regs_pkg::ADDR_PRIO0: next_hrdata[15:0] = next_regs.prio0;
        irq_regs_pkg::ADDR_PRIO1: next_hrdata[15:0] = next_regs.prio1;
        irq_regs_pkg::ADDR_STATUS: next_hrdata[1:0] = next_status;
        irq_regs_pkg::ADDR_MASK: next_hrdata[1:0] = next_mask;
        irq_regs_pkg::ADDR_LEVEL: next_hrdata[3:0] = {next_cpu_irq_req, next_cpu_irq_level};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regs.en3 <= irq_regs_pkg::EN_RESET;
      regs.en4 <= irq_regs_pkg::EN_RESET;
      regs.prio0 <= irq_regs_pkg::PRIO_RESET;
      regs.prio1 <= irq_regs_pkg::PRIO_RESET;
    end else begin
      regs <= next_regs;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      req <= next_req;
      hrdata <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp <= next_hresp;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
      cpu_irq_req <= 1'b0;
      cpu_irq_level <= irq_regs_pkg::PRIO_OFF;
    end else begin
      pending <= next_pending;
      cpu_irq_req <= next_cpu_irq_req;
      cpu_irq_level <= next_cpu_irq_level;
    end
  end

endmodule : irq_enable_priority_regs

// File: rtl/irq_regs_pkg.sv
// register map, field layouts and reset values of the interrupt enable and priority block
// assumes a single 100 MHz core clock and a 32-bit AHB-Lite register port
// Operation
// R1: enable one passes request, zero blocks it
// R2: unimplemented bits read zero, ignore writes
// R3: priority code 111 means level 7, highest
// R4: code 001 is level 1, codes map directly
// R5: code 000 disables source entirely
// R6: prio0 bits 14-12 timer1 priority
// R7: prio0 bits 10-8 output compare 1 priority
// R8: prio0 bits 6-4 input capture 1 priority
// R9: prio0 bits 2-0 external irq 0 priority
// R10: prio1 timer2, outcmp2, incap2 priority fields
// R11: prio1 bits 2-0 dma channel 0 priority
// R12: en3 bits 15,14,13 pwm1 fault, rtc, dma5
// R13: en3 bits 12,11 codec event and error
// R14: en3 bit 10 qe1, bit 9 pwm1; 8-0 zero
// R15: en4 bits 15,14 dac left and right
// R16: en4 bits 11,10,9 qe2, pwm2 fault, pwm2
// R17: en4 bits 6,5,4 can1 tx, dma7, dma6
// R18: en4 bits 3,2,1 crc, uart2 err, uart1 err
// R19: request counts only if flagged, enabled, prioritised; prioritised flags here need no enable, enable-only flags no field
package irq_regs_pkg;

  // byte addresses on the register port
  localparam logic [7:0] ADDR_EN3 = 8'h00;
  localparam logic [7:0] ADDR_EN4 = 8'h04;
  localparam logic [7:0] ADDR_PRIO0 = 8'h08;
  localparam logic [7:0] ADDR_PRIO1 = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_LEVEL = 8'h18;

  // writable bits of each register; everything else is unimplemented
  localparam logic [15:0] EN3_IMPL = 16'hFE00;
  localparam logic [15:0] EN4_IMPL = 16'hCE7E;
  localparam logic [15:0] PRIO_IMPL = 16'h7777;
  localparam logic [15:0] EN_RESET = 16'h0000;
  // priority fields come up as level 4 (100 per field)
  localparam logic [15:0] PRIO_RESET = 16'h4444;

  localparam int PRIO_W = 3;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_MAX = 3'h7;
  // enable-only sources have no priority field here, so they rank lowest
  localparam logic [2:0] PRIO_MIN = 3'h1;

  // enable bit positions in en3
  localparam int EN3_PWM1_FLT = 15;
  localparam int EN3_RTC = 14;
  localparam int EN3_DMA5 = 13;
  localparam int EN3_CODEC_EVT = 12;
  localparam int EN3_CODEC_ERR = 11;
  localparam int EN3_QE1 = 10;
  localparam int EN3_PWM1 = 9;
  // enable bit positions in en4
  localparam int EN4_DAC_L = 15;
  localparam int EN4_DAC_R = 14;
  localparam int EN4_QE2 = 11;
  localparam int EN4_PWM2_FLT = 10;
  localparam int EN4_PWM2 = 9;
  localparam int EN4_CAN1_TX = 6;
  localparam int EN4_DMA7 = 5;
  localparam int EN4_DMA6 = 4;
  localparam int EN4_CRC = 3;
  localparam int EN4_UART2_ERR = 2;
  localparam int EN4_UART1_ERR = 1;

  // field lsb positions inside a priority register
  localparam int PF3_LSB = 12;
  localparam int PF2_LSB = 8;
  localparam int PF1_LSB = 4;
  localparam int PF0_LSB = 0;

  // source count: 8 prioritised; the 18 enabled-only sources sit in two 16-bit vectors
  localparam int NUM_PRIO_SRC = 8;
  localparam int NUM_EN_SRC = 16;

  // status / mask bits
  localparam int EVT_W = 2;
  localparam int EVT_RISE = 0;
  localparam int EVT_BAD_ADDR = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic [15:0] en3;
    logic [15:0] en4;
    logic [15:0] prio0;
    logic [15:0] prio1;
  } ctrl_regs_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bus_req_s;

endpackage : irq_regs_pkg

// File: dv/cpu_core_model.sv
// cpu side: latches the level of the merged request it is offered
// assumes the request is a registered level in the core clock domain
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic cpu_irq_req, // merged request
  input wire logic [2:0] cpu_irq_level, // offered level
  output logic [2:0] taken_level // level last accepted
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) taken_level <= 3'h0;
    else if (cpu_irq_req) taken_level <= cpu_irq_level;
  end
endmodule : cpu_core_model

// File: dv/irq_regs_asserts.sv
// port checker for the enable and priority register block
// assumes one clock and the zero-wait slave described for the block
`timescale 1ns/1ps
module irq_regs_asserts (
  input wire logic core_clk, rst, hsel, hwrite, hready, // clock, reset, bus control
  input wire logic [31:0] haddr, hwdata, hrdata, // bus address and data
  input wire logic [1:0] htrans, // transfer type
  input wire logic [2:0] hsize, cpu_irq_level, // size, level out
  input wire logic hreadyout, hresp, cpu_irq_req, irq, // slave and irq outputs
  input wire logic [7:0] prio_src_req, // prioritised flags
  input wire logic [15:0] en3_src_req, en4_src_req // enable-only flags
);
  logic rd_phase;
  logic [7:0] rd_addr;
  wire xfer = hsel && hready && htrans[1];
  // unmapped reads fall to the priority layout but are not checked against it
  wire known = rd_addr inside {irq_regs_pkg::ADDR_EN3, irq_regs_pkg::ADDR_EN4,
    irq_regs_pkg::ADDR_PRIO0, irq_regs_pkg::ADDR_PRIO1};
  wire [15:0] impl = (rd_addr == irq_regs_pkg::ADDR_EN3) ? irq_regs_pkg::EN3_IMPL :
    (rd_addr == irq_regs_pkg::ADDR_EN4) ? irq_regs_pkg::EN4_IMPL : irq_regs_pkg::PRIO_IMPL;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_phase <= 1'b0;
      rd_addr <= 8'h00;
    end else begin
      rd_phase <= xfer && !hwrite;
      rd_addr <= haddr[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  no_wait_a: assert property (hreadyout && !hresp) else $error("slave stalled or erred");
  idle_rdata_a: assert property (!rd_phase |-> hrdata == 32'h0)
    else $error("read data outside a read");
  rd_upper_a: assert property (rd_phase |-> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  rd_unimpl_a: assert property (rd_phase && known |-> (hrdata[15:0] & ~impl) == 16'h0)
    else $error("unimplemented bit read one");
  req_level_a: assert property (cpu_irq_req == (cpu_irq_level != 3'h0))
    else $error("request and level disagree");
  unimpl_flags_a: assert property (prio_src_req == 8'h00
    && (en3_src_req & irq_regs_pkg::EN3_IMPL) == 16'h0
    && (en4_src_req & irq_regs_pkg::EN4_IMPL) == 16'h0 |=> !cpu_irq_req)
    else $error("request without a source");
  en_only_lvl_a: assert property (prio_src_req == 8'h00 |=> cpu_irq_level <= 3'h1)
    else $error("enable-only level above one");
  req_hold_a: assert property ($stable({prio_src_req, en3_src_req, en4_src_req})
    && !$past(xfer) && !$past(xfer, 2) |=> $stable(cpu_irq_req) && $stable(cpu_irq_level))
    else $error("request moved without cause");
endmodule : irq_regs_asserts
bind irq_enable_priority_regs irq_regs_asserts chk (.core_clk(core_clk), .rst(rst),
  .hsel(hsel), .hwrite(hwrite), .hready(hready), .haddr(haddr), .hwdata(hwdata),
  .hrdata(hrdata), .htrans(htrans), .hsize(hsize), .cpu_irq_level(cpu_irq_level),
  .hreadyout(hreadyout), .hresp(hresp), .cpu_irq_req(cpu_irq_req), .irq(irq),
  .prio_src_req(prio_src_req), .en3_src_req(en3_src_req), .en4_src_req(en4_src_req));

// File: dv/irq_enable_priority_regs_tb.sv
// self-checking bench: register rows, per-source ranking and gating, status interrupt
// assumes the zero-wait AHB-Lite slave; the cpu model sits on the request outputs
`timescale 1ns/1ps
module irq_enable_priority_regs_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, cpu_irq_req, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [7:0] prio_src_req = 0;
  logic [15:0] en3_src_req = 0, en4_src_req = 0;
  logic [2:0] cpu_irq_level, taken_level;
  logic [2:0] lv [8] = '{3'h7, 3'h5, 3'h3, 3'h1, 3'h6, 3'h4, 3'h2, 3'h0};
  int fails = 0, cmp_count = 0;
  row_s rows [12] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 32'h4444}, '{1'b0, 8'h0C, 32'h0, 32'h4444},
    '{1'b1, 8'h00, 32'hFFFF, 32'hFE00}, '{1'b1, 8'h04, 32'hFFFF, 32'hCE7E},
    '{1'b1, 8'h08, 32'hFFFFFFFF, 32'h7777}, '{1'b1, 8'h0C, 32'h8888, 32'h0},
    '{1'b1, 8'h1C, 32'hFFFF, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h2},
    '{1'b1, 8'h08, 32'h7531, 32'h7531}, '{1'b1, 8'h0C, 32'h6420, 32'h6420}};
  assign hready = hreadyout;
  always #5 core_clk = ~core_clk;
  irq_enable_priority_regs dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .prio_src_req(prio_src_req),
    .en3_src_req(en3_src_req), .en4_src_req(en4_src_req), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_level(cpu_irq_level), .irq(irq));
  cpu_core_model cpu (.core_clk(core_clk), .rst(rst), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_level(cpu_irq_level), .taken_level(taken_level));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= irq_regs_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  // outputs trail a register or flag change by one edge; two edges leave margin
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].w) xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    for (int i = 0; i < 8; i++) begin
      prio_src_req <= 8'h01 << i;
      settle();
      chk({28'h0, cpu_irq_req, cpu_irq_level}, {28'h0, |lv[i], lv[i]});
    end
    prio_src_req <= 8'hFF;
    settle();
    chk({29'h0, taken_level}, 32'h7);
    prio_src_req <= 8'h00;
    en3_src_req <= 16'hFFFF;
    en4_src_req <= 16'hFFFF;
    for (int i = 0; i < 32; i++) begin
      xfer(1'b1, irq_regs_pkg::ADDR_EN3, (i < 16) ? (32'h1 << i) : 32'h0);
      xfer(1'b1, irq_regs_pkg::ADDR_EN4, (i < 16) ? 32'h0 : (32'h1 << (i - 16)));
      settle();
      chk({28'h0, cpu_irq_req, cpu_irq_level}, ((i < 16) ? irq_regs_pkg::EN3_IMPL[i] :
        irq_regs_pkg::EN4_IMPL[i - 16]) ? 32'h9 : 32'h0);
    end
    en4_src_req <= 16'h7FFF;
    settle();
    chk({31'h0, cpu_irq_req}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, irq_regs_pkg::ADDR_MASK, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, irq_regs_pkg::ADDR_STATUS, 32'h3);
    settle();
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, irq_regs_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    // mid-run reset: registers return to their reset values, request drops
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk({28'h0, cpu_irq_req, cpu_irq_level}, 32'h0);
    xfer(1'b0, irq_regs_pkg::ADDR_PRIO1, 32'h0);
    chk(rd, {16'h0, irq_regs_pkg::PRIO_RESET});
    xfer(1'b0, irq_regs_pkg::ADDR_EN4, 32'h0);
    chk(rd, {16'h0, irq_regs_pkg::EN_RESET});
    complete_run();
  end
endmodule : irq_enable_priority_regs_tb
